/* common/sleep_ctrl_defs.svh */
// Constant definitions for the sleep mode controller.
`ifndef SLEEP_CTRL_DEFS_SVH
`define SLEEP_CTRL_DEFS_SVH
// *************************************************************************
// Mode selector codes
// *************************************************************************
`define SEL_NORMAL 4'h0
`define SEL_PIN 4'h1
`define SEL_CYCLIC 4'h4
`define SEL_CYCLIC_PIN 4'h5
`define SEL_SUPPORT 4'h7
`define SEL_SYNC_CYCLIC 4'h8
// *************************************************************************
// Time base and codes
// *************************************************************************
`define TICK_NS 1_000_000
`define CLK_NS 50
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`define POLL_TICKS 16'h0001
`define PURGE_STATUS 8'h75
`define AWAKE_PIN_ON 2'h1
`define MISS_STEP 16'h0001
`define MISS_MAX 4'h8
`endif

/* common/sleep_ctrl_pkg.sv */
// Types shared by the sleep mode controller.
package sleep_ctrl_pkg;
  typedef enum logic [2:0] {
    PWR_AWAKE, PWR_FINISH, PWR_SLEEP, PWR_LISTEN, PWR_WAKE_EXT
  } pwr_state_t;
  typedef struct packed {
    pwr_state_t pwr;
    logic [1:0] rq_sync;
    logic rq_prev;
    logic [31:0] tick_cnt;
    logic [15:0] timer;
    logic [15:0] op_sleep;
    logic [15:0] op_wake;
    logic [15:0] pend_sleep;
    logic [15:0] pend_wake;
    logic pend_valid;
    logic synced;
    logic [3:0] missed;
    logic relay_heard;
    logic resend_done;
    logic [15:0] retry_cnt;
    logic [15:0] poll_cnt;
    logic first_poll;
    logic [7:0] queued;
    logic [31:0] purge_cnt;
    logic sync_tx;
    logic relay_tx;
    logic poll_tx;
    logic deliver_tx;
    logic purge_tx;
    logic [7:0] status_code;
  } ctrl_state_t;
endpackage : sleep_ctrl_pkg

/* hw/sleep_mode_controller.sv */
// Sleep and wake sequencer for a mesh radio node.
`timescale 1ns/1ns
`include "sleep_ctrl_defs.svh"
module sleep_mode_controller #(
  parameter int TICK_CYCLES = `TICK_CYCLES,
  parameter int QUEUE_DEPTH = 4
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] sleep_mode_select_in,
  input wire logic [15:0] wake_time_setting_in,
  input wire logic [15:0] sleep_period_setting_in,
  input wire logic apply_changes_in,
  input wire logic flow_control_pin_cfg_in,
  input wire logic [1:0] awake_pin_cfg_in,
  input wire logic sleep_request_pin_in,
  input wire logic link_busy_in,
  input wire logic serial_data_in,
  input wire logic rf_data_in,
  input wire logic serial_queue_full_in,
  input wire logic is_coordinator_in,
  input wire logic is_indirect_coord_in,
  input wire logic is_poller_in,
  input wire logic is_router_in,
  input wire logic sync_rx_in,
  input wire logic [15:0] sync_rx_sleep_in,
  input wire logic [15:0] sync_rx_wake_in,
  input wire logic sync_rx_from_sleeper_in,
  input wire logic sync_request_rx_in,
  input wire logic relay_heard_in,
  input wire logic host_unicast_in,
  input wire logic host_bypass_in,
  input wire logic poll_rx_in,
  input wire logic unicast_to_dest_in,
  output logic awake_out,
  output logic cts_n_out,
  output logic rf_rx_enable_out,
  output logic uart_rx_enable_out,
  output logic data_tx_allow_out,
  output logic bypass_tx_out,
  output logic host_stall_out,
  output logic sync_tx_out,
  output logic sync_relay_out,
  output logic poll_tx_out,
  output logic deliver_tx_out,
  output logic purge_status_out,
  output logic [7:0] status_code_out,
  output logic [15:0] operating_sleep_time_out,
  output logic [15:0] operating_wake_time_out,
  output logic synced_out
);
  import sleep_ctrl_pkg::*;

  ctrl_state_t state_reg;
  ctrl_state_t state_next;

  logic tick;
  logic rq;
  logic data_ev;
  logic sleeping;
  logic cyclic;
  logic sync_mode;
  logic [15:0] eff_wake;
  logic [15:0] shrink;
  logic [31:0] purge_limit;

  // *************************************************************************
  // Helpers
  // *************************************************************************
  // Decrement that stops at zero; used by the timer, retry and poll down-counters.
  function automatic logic [15:0] dec_sat(input logic [15:0] v);
    dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
  endfunction : dec_sat

  assign tick = (state_reg.tick_cnt == 32'(TICK_CYCLES - 1));
  assign rq = state_reg.rq_sync[1];
  assign data_ev = serial_data_in | rf_data_in;
  assign sleeping = (state_reg.pwr == PWR_SLEEP);
  assign cyclic = (sleep_mode_select_in == `SEL_CYCLIC) ||
                  (sleep_mode_select_in == `SEL_CYCLIC_PIN);
  assign sync_mode = (sleep_mode_select_in == `SEL_SUPPORT) ||
                     (sleep_mode_select_in == `SEL_SYNC_CYCLIC) ||
                     (sleep_mode_select_in == `SEL_NORMAL);
  // Each missed sync, up to eight, trims the usable wake window to keep margin.
  assign shrink = 16'({12'h000, state_reg.missed}) * `MISS_STEP;
  assign eff_wake = (state_reg.op_wake > shrink) ?
                    state_reg.op_wake - shrink : 16'h0001;
  // Purge age is 2.5 sleep periods: 5/2 of the period in ticks.
  assign purge_limit = ({16'h0000, state_reg.op_sleep} * 32'd5) >> 1;

  // *************************************************************************
  // Next state
  // *************************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.sync_tx = 1'b0;
    state_next.relay_tx = 1'b0;
    state_next.poll_tx = 1'b0;
    state_next.deliver_tx = 1'b0;
    state_next.purge_tx = 1'b0;
    state_next.rq_sync = {state_reg.rq_sync[0], sleep_request_pin_in};
    state_next.rq_prev = rq;
    state_next.tick_cnt = tick ? 32'h0000_0000 : state_reg.tick_cnt + 1;
    if (tick) begin
      state_next.timer = dec_sat(state_reg.timer);
    end
    if (apply_changes_in) begin
      state_next.pend_sleep = sleep_period_setting_in;
      state_next.pend_wake = wake_time_setting_in;
      state_next.pend_valid = 1'b1;
      if (!state_reg.synced) begin
        state_next.op_sleep = sleep_period_setting_in;
        state_next.op_wake = wake_time_setting_in;
      end
    end
    // A sleeping radio hears nothing, so syncs are taken only while awake.
    if (sync_rx_in && sync_mode && !sleeping) begin
      state_next.synced = 1'b1;
      state_next.missed = 4'h0;
      state_next.op_sleep = sync_rx_sleep_in;
      state_next.op_wake = sync_rx_wake_in;
      state_next.relay_tx = is_router_in &&
        (sleep_mode_select_in != `SEL_NORMAL || sync_rx_from_sleeper_in ||
         state_reg.synced);
      if (state_reg.pwr == PWR_LISTEN) begin
        state_next.pwr = PWR_AWAKE;
        state_next.timer = sync_rx_wake_in;
      end
    end
    if (sync_request_rx_in && state_reg.synced &&
        sleep_mode_select_in != `SEL_NORMAL) begin
      state_next.sync_tx = 1'b1;
    end
    if (relay_heard_in) begin
      state_next.relay_heard = 1'b1;
    end

    case (state_reg.pwr)
      PWR_AWAKE: begin
        case (sleep_mode_select_in)
          `SEL_NORMAL, `SEL_SUPPORT: begin
            state_next.pwr = PWR_AWAKE;
          end
          `SEL_PIN: begin
            if (rq) begin
              state_next.pwr = PWR_FINISH;
            end
          end
          `SEL_CYCLIC, `SEL_CYCLIC_PIN: begin
            if (data_ev) begin
              state_next.timer = state_reg.op_wake;
            end else if (state_reg.timer == 16'h0000) begin
              state_next.pwr = PWR_SLEEP;
              state_next.timer = state_reg.op_sleep;
            end
          end
          `SEL_SYNC_CYCLIC: begin
            if (!state_reg.synced) begin
              state_next.pwr = PWR_LISTEN;
              state_next.timer = state_reg.op_wake;
            end else if (tick && state_reg.timer == 16'h0000) begin
              state_next.pwr = PWR_SLEEP;
              state_next.timer = state_reg.op_sleep;
            end
          end
          default: begin
            state_next.pwr = PWR_AWAKE;
          end
        endcase
      end
      PWR_FINISH: begin
        if (!rq) begin
          state_next.pwr = PWR_AWAKE;
        end else if (!link_busy_in) begin
          state_next.pwr = PWR_SLEEP;
        end
      end
      PWR_LISTEN: begin
        if (tick && state_reg.timer == 16'h0000) begin
          state_next.pwr = PWR_SLEEP;
          state_next.timer = state_reg.op_sleep;
        end
      end
      PWR_SLEEP: begin
        if (sleep_mode_select_in == `SEL_PIN) begin
          if (!rq) begin
            state_next.pwr = PWR_WAKE_EXT;
          end
        end else if (sleep_mode_select_in == `SEL_CYCLIC_PIN &&
                     state_reg.rq_prev && !rq) begin
          state_next.pwr = PWR_WAKE_EXT;
        end else if (sleep_mode_select_in == `SEL_NORMAL ||
                     sleep_mode_select_in == `SEL_SUPPORT) begin
          state_next.pwr = PWR_AWAKE;
        end else if (state_reg.timer == 16'h0000) begin
          state_next.pwr = PWR_WAKE_EXT;
        end
      end
      PWR_WAKE_EXT: begin
        // Wake start: apply pending settings and arm the wake window.
        state_next.pwr = PWR_AWAKE;
        if (state_reg.pend_valid) begin
          state_next.op_sleep = state_reg.pend_sleep;
          state_next.op_wake = state_reg.pend_wake;
          state_next.pend_valid = 1'b0;
        end
        state_next.timer = cyclic ? `POLL_TICKS : eff_wake;
        state_next.first_poll = is_poller_in;
        if (sleep_mode_select_in == `SEL_SYNC_CYCLIC && state_reg.synced &&
            !is_coordinator_in) begin
          state_next.missed = (state_reg.missed == `MISS_MAX) ?
                              `MISS_MAX : state_reg.missed + 4'h1;
        end
        if (is_coordinator_in && sync_mode) begin
          state_next.sync_tx = 1'b1;
          // A relay heard in this very cycle must not be lost to the clear.
          state_next.relay_heard = relay_heard_in;
          state_next.resend_done = 1'b0;
          state_next.retry_cnt = `POLL_TICKS;
        end
      end
      default: begin
        state_next.pwr = PWR_AWAKE;
      end
    endcase

    // Coordinator resend when no neighbour relay was heard.
    if (is_coordinator_in && !state_reg.resend_done && tick) begin
      state_next.retry_cnt = dec_sat(state_reg.retry_cnt);
      if (state_reg.retry_cnt == 16'h0000) begin
        state_next.resend_done = 1'b1;
        state_next.sync_tx = !state_reg.relay_heard;
      end
    end

    // Polling: first poll soon after wake, then periodic.
    if (is_poller_in && !sleeping) begin
      if (unicast_to_dest_in) begin
        state_next.poll_cnt = state_reg.op_sleep;
        state_next.first_poll = 1'b0;
      end else if (state_reg.first_poll) begin
        state_next.poll_tx = 1'b1;
        state_next.first_poll = 1'b0;
        state_next.poll_cnt = state_reg.op_sleep;
      end else if (tick) begin
        state_next.poll_cnt = dec_sat(state_reg.poll_cnt);
        if (state_reg.poll_cnt == 16'h0000) begin
          state_next.poll_tx = 1'b1;
          state_next.poll_cnt = state_reg.op_sleep;
        end
      end
    end

    // Indirect queue: a poll frees one slot, a purge frees one slot.
    if (is_indirect_coord_in) begin
      if (poll_rx_in && state_reg.queued != 8'h00) begin
        state_next.deliver_tx = 1'b1;
        state_next.queued = state_reg.queued - 8'h01;
        state_next.purge_cnt = 32'h0000_0000;
      end else if (state_reg.queued != 8'h00 && tick) begin
        state_next.purge_cnt = state_reg.purge_cnt + 1;
        if (state_reg.purge_cnt >= purge_limit) begin
          state_next.purge_tx = 1'b1;
          state_next.status_code = `PURGE_STATUS;
          state_next.queued = state_reg.queued - 8'h01;
          state_next.purge_cnt = 32'h0000_0000;
        end
      end
      if (host_unicast_in && state_reg.queued != 8'(QUEUE_DEPTH) &&
          !host_bypass_in) begin
        state_next.queued = state_next.queued + 8'h01;
      end
    end
    if (state_reg.queued == 8'h00) begin
      state_next.purge_cnt = 32'h0000_0000;
    end
  end

  // *************************************************************************
  // State register
  // *************************************************************************
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= '0;
      // No sync has gone out yet, so there is nothing to resend.
      state_reg.resend_done <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // *************************************************************************
  // Outputs
  // *************************************************************************
  always_comb begin
    awake_out = !sleeping;
    if (sleep_mode_select_in == `SEL_SYNC_CYCLIC &&
        awake_pin_cfg_in != `AWAKE_PIN_ON) begin
      awake_out = 1'b0;
    end
    if (cyclic) begin
      awake_out = !sleeping;
    end
  end
  // The block cannot see the serial FIFO, so the host side reports fullness.
  assign host_stall_out = is_indirect_coord_in &&
    (state_reg.queued == 8'(QUEUE_DEPTH)) && host_unicast_in;
  assign cts_n_out = flow_control_pin_cfg_in &&
    (sleeping || serial_queue_full_in);
  assign rf_rx_enable_out = !sleeping;
  assign uart_rx_enable_out = !sleeping;
  assign data_tx_allow_out = !sleeping &&
    ((sleep_mode_select_in == `SEL_NORMAL) ||
     (sleep_mode_select_in == `SEL_SUPPORT ? state_reg.timer != 16'h0000
                                            : 1'b1));
  assign bypass_tx_out = host_bypass_in && !sleeping;
  assign sync_tx_out = state_reg.sync_tx &&
                       sleep_mode_select_in != `SEL_NORMAL;
  assign sync_relay_out = state_reg.relay_tx;
  assign poll_tx_out = state_reg.poll_tx;
  assign deliver_tx_out = state_reg.deliver_tx;
  assign purge_status_out = state_reg.purge_tx;
  assign status_code_out = state_reg.status_code;
  assign operating_sleep_time_out = state_reg.op_sleep;
  assign operating_wake_time_out = state_reg.op_wake;
  assign synced_out = state_reg.synced;
endmodule : sleep_mode_controller

/* tb/peer_node_model.sv */
// Peer radio node that sends sync frames on command and relays heard syncs.
`timescale 1ns/1ns
module peer_node_model #(
  parameter logic [15:0] SLEEP_TIME = 16'h0006,
  parameter logic [15:0] WAKE_TIME = 16'h0002
) (
  input wire logic core_clk_in,
  input wire logic send_in,
  input wire logic relay_en_in,
  input wire logic tx_seen_in,
  output logic sync_out = 1'b0,
  output logic [15:0] sync_sleep_out,
  output logic [15:0] sync_wake_out,
  output logic relay_out = 1'b0
);
  always_ff @(posedge core_clk_in) begin
    sync_out <= send_in;
    relay_out <= relay_en_in && tx_seen_in;
  end
  // Times are valid only beside the strobe, so a late sampler sees junk.
  assign sync_sleep_out = sync_out ? SLEEP_TIME : ~SLEEP_TIME;
  assign sync_wake_out = sync_out ? WAKE_TIME : ~WAKE_TIME;
endmodule : peer_node_model

/* tb/sleep_ctrl_assertions.sv */
// Port-level checker for the sleep mode controller.
`timescale 1ns/1ns
module sleep_ctrl_assertions (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] sleep_mode_select_in,
  input wire logic flow_control_pin_cfg_in,
  input wire logic link_busy_in,
  input wire logic serial_queue_full_in,
  input wire logic is_indirect_coord_in,
  input wire logic sync_rx_in,
  input wire logic sync_request_rx_in,
  input wire logic awake_out,
  input wire logic cts_n_out,
  input wire logic rf_rx_enable_out,
  input wire logic uart_rx_enable_out,
  input wire logic sync_tx_out,
  input wire logic purge_status_out,
  input wire logic [7:0] status_code_out,
  input wire logic synced_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic [3:0] sel = sleep_mode_select_in;
  property p_normal_awake;
    sel == 4'h0 && $past(sel) == 4'h0 |-> awake_out;
  endproperty
  a_normal_awake: assert property (p_normal_awake)
    else $error("normal mode went to sleep");
  property p_normal_no_sync;
    sel == 4'h0 && $past(sel) == 4'h0 |-> !sync_tx_out;
  endproperty
  a_normal_no_sync: assert property (p_normal_no_sync)
    else $error("normal mode originated a sync");
  property p_support_awake;
    sel == 4'h7 && $past(sel) == 4'h7 |-> awake_out;
  endproperty
  a_support_awake: assert property (p_support_awake)
    else $error("support mode went to sleep");
  property p_support_answer;
    sel == 4'h7 && synced_out && sync_request_rx_in |-> ##[1:2] sync_tx_out;
  endproperty
  a_support_answer: assert property (p_support_answer)
    else $error("join request got no sync");
  property p_pin_busy;
    sel == 4'h1 && awake_out && link_busy_in && $past(link_busy_in)
      |=> awake_out;
  endproperty
  a_pin_busy: assert property (p_pin_busy)
    else $error("slept during link activity");
  property p_cts_sleep;
    flow_control_pin_cfg_in && !awake_out |-> cts_n_out;
  endproperty
  a_cts_sleep: assert property (p_cts_sleep)
    else $error("clear to send while asleep");
  property p_sync_mute;
    sel == 4'h8 && !awake_out |-> !rf_rx_enable_out && !uart_rx_enable_out;
  endproperty
  a_sync_mute: assert property (p_sync_mute)
    else $error("receivers open while asleep");
  property p_sync_adopt;
    (sel == 4'h8 || sel == 4'h7) && sync_rx_in && rf_rx_enable_out
      |-> ##[1:3] synced_out;
  endproperty
  a_sync_adopt: assert property (p_sync_adopt)
    else $error("sync frame not adopted");
  property p_purge_code;
    purge_status_out |-> ##[0:1] status_code_out == 8'h75;
  endproperty
  a_purge_code: assert property (p_purge_code)
    else $error("purge status code wrong");
  property p_cts_full;
    flow_control_pin_cfg_in && is_indirect_coord_in && serial_queue_full_in
      && $past(serial_queue_full_in) |-> cts_n_out;
  endproperty
  a_cts_full: assert property (p_cts_full)
    else $error("clear to send with full serial queue");
endmodule : sleep_ctrl_assertions
bind sleep_mode_controller sleep_ctrl_assertions u_chk (.core_clk_in,
  .sys_rst_in, .sleep_mode_select_in, .flow_control_pin_cfg_in,
  .link_busy_in, .serial_queue_full_in, .is_indirect_coord_in, .sync_rx_in,
  .sync_request_rx_in, .awake_out, .cts_n_out, .rf_rx_enable_out,
  .uart_rx_enable_out, .sync_tx_out, .purge_status_out, .status_code_out,
  .synced_out);

/* tb/sleep_mode_controller_tb.sv */
// Self-checking testbench for the sleep mode controller.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  num_errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module sleep_mode_controller_tb;
  import sleep_ctrl_pkg::*;
  localparam logic [15:0] PEER_SLEEP = 16'h0006;
  localparam logic [15:0] PEER_WAKE = 16'h0002;
  logic core_clk_in = 1'b0, sys_rst_in = 1'b1, apply_changes_in = 1'b0;
  logic [3:0] sleep_mode_select_in = 4'h0;
  logic [15:0] wake_time_setting_in = 16'h0003;
  logic [15:0] sleep_period_setting_in = 16'h0004;
  logic [1:0] awake_pin_cfg_in = 2'h1;
  logic flow_control_pin_cfg_in = 1'b1, sleep_request_pin_in = 1'b0;
  logic link_busy_in = 0, serial_data_in = 0, rf_data_in = 0;
  logic serial_queue_full_in = 0, is_coordinator_in = 0, is_router_in = 0;
  logic is_indirect_coord_in = 0, is_poller_in = 0, poll_rx_in = 0;
  logic sync_request_rx_in = 0, host_unicast_in = 0, host_bypass_in = 0;
  logic unicast_to_dest_in = 0, sync_rx_from_sleeper_in = 0;
  logic relay_en = 0, peer_send = 0, got;
  logic sync_rx_in, relay_heard_in;
  logic [15:0] sync_rx_sleep_in, sync_rx_wake_in;
  logic awake_out, cts_n_out, rf_rx_enable_out, uart_rx_enable_out;
  logic data_tx_allow_out, bypass_tx_out, host_stall_out, sync_tx_out;
  logic sync_relay_out, poll_tx_out, deliver_tx_out, purge_status_out;
  logic synced_out;
  logic [7:0] status_code_out;
  logic [15:0] operating_sleep_time_out, operating_wake_time_out;
  int num_errors = 0, checks_done = 0, cycles = 0;
  // A tick of four clocks keeps every window a few cycles wide.
  sleep_mode_controller #(.TICK_CYCLES(4), .QUEUE_DEPTH(4)) dut (.*);
  peer_node_model #(.SLEEP_TIME(PEER_SLEEP), .WAKE_TIME(PEER_WAKE)) peer (
    .core_clk_in, .send_in(peer_send), .relay_en_in(relay_en),
    .tx_seen_in(sync_tx_out), .sync_out(sync_rx_in),
    .sync_sleep_out(sync_rx_sleep_in), .sync_wake_out(sync_rx_wake_in),
    .relay_out(relay_heard_in));
  initial begin
    forever #25 core_clk_in = ~core_clk_in;
  end
  task stop_test;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  function automatic logic pick(input int s);
    case (s)
      0: pick = awake_out;
      1: pick = synced_out;
      2: pick = sync_tx_out;
      3: pick = rf_rx_enable_out;
      4: pick = deliver_tx_out;
      5: pick = purge_status_out;
      default: pick = poll_tx_out;
    endcase
  endfunction : pick
  task wait_for(input string n, input int s, input logic v, input int max);
    got = 1'b0;
    for (int i = 0; i < max && !got; i++) begin
      @(negedge core_clk_in);
      got = (pick(s) === v);
    end
    `CHK(n, 1'b1, got)
  endtask : wait_for
  task restart(input logic [3:0] m);
    @(posedge core_clk_in);
    sys_rst_in <= 1'b1;
    sleep_mode_select_in <= m;
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    apply_changes_in <= 1'b1;
    @(posedge core_clk_in);
    apply_changes_in <= 1'b0;
  endtask : restart
  task peer_sync;
    @(posedge core_clk_in);
    peer_send <= 1'b1;
    @(posedge core_clk_in);
    peer_send <= 1'b0;
  endtask : peer_sync
  initial begin
    repeat (20) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (40) @(negedge core_clk_in);
    `CHK("normal awake", 1'b1, awake_out)
    restart(4'h1);
    sleep_request_pin_in <= 1'b1;
    link_busy_in <= 1'b1;
    repeat (10) @(negedge core_clk_in);
    `CHK("busy awake", 1'b1, awake_out)
    @(posedge core_clk_in) link_busy_in <= 1'b0;
    wait_for("pin sleep", 0, 1'b0, 20);
    `CHK("cts asleep", 1'b1, cts_n_out)
    @(posedge core_clk_in) sleep_request_pin_in <= 1'b0;
    wait_for("pin wake", 0, 1'b1, 20);
    repeat (2) @(negedge core_clk_in);
    `CHK("cts awake", 1'b0, cts_n_out)
    restart(4'h4);
    wait_for("cyclic sleep", 0, 1'b0, 60);
    wait_for("cyclic wake", 0, 1'b1, 80);
    @(posedge core_clk_in) rf_data_in <= 1'b1;
    @(posedge core_clk_in) rf_data_in <= 1'b0;
    repeat (8) @(negedge core_clk_in);
    `CHK("rf extends", 1'b1, awake_out)
    @(posedge core_clk_in) serial_data_in <= 1'b1;
    @(posedge core_clk_in) serial_data_in <= 1'b0;
    repeat (8) @(negedge core_clk_in);
    `CHK("serial restarts", 1'b1, awake_out)
    wait_for("timer expiry", 0, 1'b0, 16);
    sleep_period_setting_in <= 16'h0040;
    restart(4'h5);
    wait_for("pin wake sleep", 0, 1'b0, 60);
    @(posedge core_clk_in) sleep_request_pin_in <= 1'b1;
    repeat (6) @(posedge core_clk_in);
    sleep_request_pin_in <= 1'b0;
    wait_for("early wake", 0, 1'b1, 12);
    sleep_period_setting_in <= 16'h0004;
    restart(4'h7);
    peer_sync();
    wait_for("support synced", 1, 1'b1, 10);
    `CHK("op sleep", PEER_SLEEP, operating_sleep_time_out)
    @(posedge core_clk_in) sync_request_rx_in <= 1'b1;
    @(posedge core_clk_in) sync_request_rx_in <= 1'b0;
    wait_for("join answer", 2, 1'b1, 4);
    restart(4'h8);
    wait_for("unsynced sleep", 3, 1'b0, 20);
    wait_for("listen", 3, 1'b1, 40);
    peer_sync();
    wait_for("sleeper synced", 1, 1'b1, 10);
    `CHK("op wake", PEER_WAKE, operating_wake_time_out)
    wait_for("network sleep", 0, 1'b0, 40);
    `CHK("uart closed", 1'b0, uart_rx_enable_out)
    is_coordinator_in <= 1'b1;
    restart(4'h8);
    wait_for("coord sync", 2, 1'b1, 200);
    wait_for("coord resend", 2, 1'b1, 12);
    is_coordinator_in <= 1'b0;
    is_indirect_coord_in <= 1'b1;
    is_poller_in <= 1'b1;
    sleep_period_setting_in <= 16'h0002;
    restart(4'h0);
    host_unicast_in <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    serial_queue_full_in <= 1'b1;
    repeat (2) @(negedge core_clk_in);
    `CHK("queue stall", 1'b1, host_stall_out)
    `CHK("cts full", 1'b1, cts_n_out)
    @(posedge core_clk_in) poll_rx_in <= 1'b1;
    host_unicast_in <= 1'b0;
    @(posedge core_clk_in) poll_rx_in <= 1'b0;
    serial_queue_full_in <= 1'b0;
    wait_for("deliver", 4, 1'b1, 4);
    @(negedge core_clk_in);
    `CHK("stall freed", 1'b0, host_stall_out)
    wait_for("poll", 6, 1'b1, 40);
    wait_for("purge", 5, 1'b1, 80);
    @(negedge core_clk_in);
    `CHK("purge code", 8'h75, status_code_out)
    stop_test();
  end
endmodule : sleep_mode_controller_tb
